// file: hdl/sol_monitor.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sol_monitor #(
  parameter int TICK_CYCLES = sol_pkg::TICK_US * sol_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // output terminals and readback
  output logic [3:0] out_drv,
  input wire logic [3:0] out_fb,
  // supply monitor comparators
  input wire logic pwr_low,
  input wire logic pwr_high,
  // reported status
  output logic [3:0] out_status,
  output logic pwr_ok,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [1:0] dual;
  logic [3:0] tp_en;
  logic [12:0] latch_units;
  logic [6:0] tp_width;
  logic [3:0] req;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;

  logic wr_ctrl, wr_latch, wr_tpw, wr_req, wr_istat, wr_imask;
  logic [12:0] latch_in;
  logic [6:0] tpw_in;

  // address decode
  assign wr_ctrl = reg_wr && reg_addr == sol_pkg::REG_CTRL;
  assign wr_latch = reg_wr && reg_addr == sol_pkg::REG_LATCH;
  assign wr_tpw = reg_wr && reg_addr == sol_pkg::REG_TPW;
  assign wr_req = reg_wr && reg_addr == sol_pkg::REG_OUTREQ;
  assign wr_istat = reg_wr && reg_addr == sol_pkg::REG_IRQ_STAT;
  assign wr_imask = reg_wr && reg_addr == sol_pkg::REG_IRQ_MASK;

  // clamp written values into their legal ranges
  always_comb begin
    if (reg_wdata[31:13] != 19'h00000 || reg_wdata[12:0] > sol_pkg::LATCH_MAX) begin
      latch_in = sol_pkg::LATCH_MAX;
    end else begin
      latch_in = reg_wdata[12:0];
    end
    if (reg_wdata[31:7] != 25'h0000000 || reg_wdata[6:0] > sol_pkg::TP_W_MAX) begin
      tpw_in = sol_pkg::TP_W_MAX;
    end else if (reg_wdata[6:0] < sol_pkg::TP_W_MIN) begin
      tpw_in = sol_pkg::TP_W_MIN;
    end else begin
      tpw_in = reg_wdata[6:0];
    end
  end

  // pairing and pulse enables
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dual <= 2'h0;
      tp_en <= 4'h0;
    end else if (wr_ctrl) begin
      dual <= reg_wdata[sol_pkg::CTRL_DUAL_LSB +: 2];
      tp_en <= reg_wdata[sol_pkg::CTRL_TP_LSB +: 4];
    end
  end

  // single latch time for every output
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_units <= sol_pkg::LATCH_DEF;
    end else if (wr_latch) begin
      latch_units <= latch_in;
    end
  end

  // test pulse width
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tp_width <= sol_pkg::TP_W_DEF;
    end else if (wr_tpw) begin
      tp_width <= tpw_in;
    end
  end

  // requested process values
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req <= 4'h0;
    end else if (wr_req) begin
      req <= reg_wdata[3:0];
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_mask <= 5'h00;
    end else if (wr_imask) begin
      irq_mask <= reg_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base

  sol_time_if tm ();

  assign tm.pulse_width = tp_width;

  sol_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tm(tm)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-output fault detection and latching

  logic pwr_fault;
  logic [3:0] drv_q;
  logic [3:0] err;
  logic [3:0] raw;
  logic [3:0] short_det;
  logic [3:0] slot;
  logic [3:0] pulse_act;
  logic [3:0] on_cmd;
  logic [3:0] next_drv;
  logic [3:0] next_status;
  logic [3:0] err_set;
  logic [12:0] lcnt [4];
  logic [1:0] mismatch;
  logic [1:0] pair_err;

  assign pwr_fault = pwr_low | pwr_high;

  // pair level terms
  for (genvar p = 0; p < sol_pkg::NUM_PAIR; p++) begin : g_pair
    assign mismatch[p] = dual[p] && (req[2*p] != req[2*p+1]);
    assign pair_err[p] = err[2*p] | err[2*p+1];
  end

  for (genvar g = 0; g < sol_pkg::NUM_OUT; g++) begin : g_ch
    localparam int P = g ^ 1;
    logic stable;
    logic off_fault;
    logic gnd_fault;
    logic want_on;

    // even outputs share the first pulse slot of the period, odd outputs the second
    assign slot[g] = (g % 2 == 1) ? tm.pulse_odd : tm.pulse_even;

    // equivalent pairs need both requests high
    assign want_on = dual[g/2] ? (req[2*(g/2)] & req[2*(g/2)+1]) : req[g];
    assign on_cmd[g] = want_on && !pair_err[g/2] && !pwr_fault;
    assign pulse_act[g] = tp_en[g] && slot[g] && on_cmd[g];
    assign next_drv[g] = on_cmd[g] && !pulse_act[g];

    // readback only judged once the drive has settled a cycle
    assign stable = out_drv[g] == drv_q[g];
    // high while off covers pulse gaps, so ON contact needs pulses
    assign off_fault = stable && !out_drv[g] && out_fb[g];
    assign gnd_fault = stable && out_drv[g] && !out_fb[g];
    // partner pulsed low yet reads high while this one is on
    assign short_det[g] = dual[g/2] && pulse_act[P] && !out_drv[P] && drv_q[P] == out_drv[P] &&
                          out_drv[g] && out_fb[P];
    assign raw[g] = off_fault | gnd_fault | short_det[g];
    assign err_set[g] = raw[g] && !err[g];

    // latch timer, reloaded while the fault persists
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        err[g] <= 1'b0;
        lcnt[g] <= 13'h0000;
      end else if (raw[g]) begin
        err[g] <= 1'b1;
        lcnt[g] <= latch_units;
      end else if (lcnt[g] != 13'h0000) begin
        if (tm.tick_step) begin
          lcnt[g] <= lcnt[g] - 13'h0001;
        end
      end else begin
        err[g] <= 1'b0;
      end
    end

    // reported status for this output
    assign next_status[g] = !pwr_fault && !err[g] && !raw[g] && !mismatch[g/2];
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // terminal drive, delayed copy for settling
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_drv <= 4'h0;
      drv_q <= 4'h0;
    end else begin
      out_drv <= next_drv;
      drv_q <= out_drv;
    end
  end

  // status flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_status <= 4'h0;
      pwr_ok <= 1'b0;
    end else begin
      out_status <= next_status;
      pwr_ok <= !pwr_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [4:0] irq_events;
  logic [4:0] next_irq_stat;

  assign irq_events = {pwr_fault && pwr_ok, err_set};

  // sticky, write one to clear, a new event wins
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_istat) begin
      next_irq_stat = irq_stat & ~reg_wdata[4:0];
    end
    next_irq_stat = next_irq_stat | irq_events;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat <= 5'h00;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (reg_addr)
      sol_pkg::REG_CTRL: begin
        next_rdata[sol_pkg::CTRL_DUAL_LSB +: 2] = dual;
        next_rdata[sol_pkg::CTRL_TP_LSB +: 4] = tp_en;
      end
      sol_pkg::REG_LATCH: next_rdata[12:0] = latch_units;
      sol_pkg::REG_TPW: next_rdata[6:0] = tp_width;
      sol_pkg::REG_OUTREQ: next_rdata[3:0] = req;
      sol_pkg::REG_STATUS: begin
        next_rdata[sol_pkg::STAT_OK_LSB +: 4] = out_status;
        next_rdata[sol_pkg::STAT_PWR_BIT] = pwr_ok;
        next_rdata[sol_pkg::STAT_DRV_LSB +: 4] = out_drv;
        next_rdata[sol_pkg::STAT_ERR_LSB +: 4] = err;
      end
      sol_pkg::REG_IRQ_STAT: next_rdata[4:0] = irq_stat;
      sol_pkg::REG_IRQ_MASK: next_rdata[4:0] = irq_mask;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  pwr_safe_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwr_fault |=> (out_drv == 4'h0 && out_status == 4'h0))
    else $error("outputs not safe during supply fault");

  // flag still shows its reset value in the first cycle after release
  pwr_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> pwr_ok == !$past(pwr_fault))
    else $error("supply health flag wrong");

  pair_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (err[0] || err[1]) |=> out_drv[1:0] == 2'h0)
    else $error("pair not switched off on error");

  dual_mismatch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dual[0] && req[0] != req[1]) |=> (out_drv[1:0] == 2'h0 && out_status[1:0] == 2'h0))
    else $error("mismatched pair not off");

  latch_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    raw[0] |=> (err[0] && lcnt[0] == $past(latch_units)))
    else $error("latch timer not restarted");

  latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (err[3] && lcnt[3] != 13'h0000) |=> !out_status[3])
    else $error("status cleared before latch expiry");

  latch_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    latch_units <= sol_pkg::LATCH_MAX)
    else $error("latch time out of range");

  latch_default_a: assert property (@(posedge core_clk)
    !rst_n |=> (latch_units == sol_pkg::LATCH_DEF && tp_width == sol_pkg::TP_W_DEF))
    else $error("reset defaults wrong");

  short_dual_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    short_det[0] |-> (dual[0] && tp_en[1] && out_drv[0]) ##1 err[0])
    else $error("short flagged outside paired pulsed mode");

  pulse_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tp_width >= sol_pkg::TP_W_MIN && tp_width <= sol_pkg::TP_W_MAX)
    else $error("pulse width out of range");

  cov_pulse_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    pulse_act[3] ##1 !out_drv[3]);

  cov_short_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    short_det[0]);

  cov_expire_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(err[0]));

  cov_pwr_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(pwr_ok));

endmodule

`default_nettype wire

// file: hdl/sol_pkg.sv
`default_nettype none

package sol_pkg;

  // clock and time base
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 100;
  localparam int LATCH_STEP_MS = 10;
  localparam int TP_PERIOD_MS = 468;
  localparam int TICKS_PER_STEP = LATCH_STEP_MS * 1000 / TICK_US;
  localparam int TP_PERIOD_TICKS = TP_PERIOD_MS * 1000 / TICK_US;
  localparam int TP_HALF_TICKS = TP_PERIOD_TICKS / 2;

  // channel count
  localparam int NUM_OUT = 4;
  localparam int NUM_PAIR = 2;

  // test pulse width, in 100 us units
  localparam logic [6:0] TP_W_MIN = 7'h03;
  localparam logic [6:0] TP_W_MAX = 7'h64;
  localparam logic [6:0] TP_W_DEF = 7'h05;

  // latch time, in 10 ms units
  localparam logic [12:0] LATCH_MAX = 13'h1999;
  localparam logic [12:0] LATCH_DEF = 13'h0064;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LATCH = 8'h04;
  localparam logic [7:0] REG_TPW = 8'h08;
  localparam logic [7:0] REG_OUTREQ = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // field positions
  localparam int CTRL_DUAL_LSB = 0;
  localparam int CTRL_TP_LSB = 4;
  localparam int STAT_OK_LSB = 0;
  localparam int STAT_PWR_BIT = 4;
  localparam int STAT_DRV_LSB = 8;
  localparam int STAT_ERR_LSB = 12;
  localparam int IRQ_PWR_BIT = 4;
  localparam int IRQ_W = 5;

endpackage

`default_nettype wire

// file: hdl/sol_time_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sol_time_if;
  logic tick_step;
  logic pulse_even;
  logic pulse_odd;
  logic [6:0] pulse_width;

  // timebase drives ticks and pulse slots
  modport src (output tick_step, output pulse_even, output pulse_odd, input pulse_width);
  // monitor consumes them
  modport dst (input tick_step, input pulse_even, input pulse_odd, output pulse_width);
endinterface

`default_nettype wire

// file: hdl/sol_timebase.sv
`timescale 1ns/1ps
`default_nettype none

module sol_timebase #(
  parameter int TICK_CYCLES = sol_pkg::TICK_US * sol_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ticks and pulse slots
  sol_time_if.src tm
);

  logic [14:0] sub_cnt;
  logic tick_base;
  logic [6:0] step_cnt;
  logic [12:0] per_cnt;

  // 100 us base tick from the core clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sub_cnt <= 15'h0000;
      tick_base <= 1'b0;
    end else if (sub_cnt == 15'(TICK_CYCLES - 1)) begin
      sub_cnt <= 15'h0000;
      tick_base <= 1'b1;
    end else begin
      sub_cnt <= sub_cnt + 15'h0001;
      tick_base <= 1'b0;
    end
  end

  // 10 ms step tick shared by the per-output latch timers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step_cnt <= 7'h00;
      tm.tick_step <= 1'b0;
    end else if (tick_base && step_cnt == 7'(sol_pkg::TICKS_PER_STEP - 1)) begin
      step_cnt <= 7'h00;
      tm.tick_step <= 1'b1;
    end else begin
      if (tick_base) begin
        step_cnt <= step_cnt + 7'h01;
      end
      tm.tick_step <= 1'b0;
    end
  end

  // fixed test pulse period
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      per_cnt <= 13'h0000;
    end else if (tick_base) begin
      if (per_cnt == 13'(sol_pkg::TP_PERIOD_TICKS - 1)) begin
        per_cnt <= 13'h0000;
      end else begin
        per_cnt <= per_cnt + 13'h0001;
      end
    end
  end

  // even channels pulse at period start, odd ones half a period later
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tm.pulse_even <= 1'b0;
      tm.pulse_odd <= 1'b0;
    end else begin
      tm.pulse_even <= per_cnt < {6'h00, tm.pulse_width};
      tm.pulse_odd <= (per_cnt >= 13'(sol_pkg::TP_HALF_TICKS)) &&
                      (per_cnt < 13'(sol_pkg::TP_HALF_TICKS) + {6'h00, tm.pulse_width});
    end
  end

endmodule

`default_nettype wire

// file: tb/sol_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module sol_load_model (
  // terminal drive from the block
  input wire logic [3:0] out_drv,
  // injected wiring faults
  input wire logic [3:0] stuck_hi,
  input wire logic [3:0] stuck_lo,
  // readback to the block
  output logic [3:0] out_fb
);
  // wire contact to 24v wins, then short to 0v, else the load follows the drive
  always_comb begin
    out_fb = (out_drv & ~stuck_lo) | stuck_hi;
  end
endmodule

`default_nettype wire

// file: tb/sol_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sol_monitor_tb;
  // design ports
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] out_drv;
  logic [3:0] out_fb;
  logic pwr_low = 1'b0;
  logic pwr_high = 1'b0;
  logic [3:0] out_status;
  logic pwr_ok;
  logic irq;
  logic [3:0] stuck_hi = 4'h0;
  logic [3:0] stuck_lo = 4'h0;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] d;

  // short base tick keeps latch steps and the pulse period in reach
  localparam int TB_TICK = 10;

  // 250 mhz clock
  always #2 core_clk = ~core_clk;

  sol_monitor #(.TICK_CYCLES(TB_TICK)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_drv(out_drv),
    .out_fb(out_fb), .pwr_low(pwr_low), .pwr_high(pwr_high), .out_status(out_status),
    .pwr_ok(pwr_ok), .irq(irq)
  );

  sol_load_model i_load (.out_drv(out_drv), .stuck_hi(stuck_hi), .stuck_lo(stuck_lo), .out_fb(out_fb));

  ////////////////////////////////////////////////////////////////
  // bus and compare helpers
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(sol_pkg::REG_LATCH, d);
    chk(d, 32'h64);
    rd(sol_pkg::REG_TPW, d);
    chk(d, 32'h5);
    chk({31'h0, pwr_ok}, 32'h1);
    chk({28'h0, out_drv}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(sol_pkg::REG_LATCH, 32'hFFFF);
    rd(sol_pkg::REG_LATCH, d);
    chk(d, 32'h1999);
    wr(sol_pkg::REG_LATCH, 32'h0);
    rd(sol_pkg::REG_LATCH, d);
    chk(d, 32'h0);
    wr(sol_pkg::REG_TPW, 32'h0);
    rd(sol_pkg::REG_TPW, d);
    chk(d, 32'h3);
    wr(sol_pkg::REG_TPW, 32'h7F);
    rd(sol_pkg::REG_TPW, d);
    chk(d, 32'h64);
    wr(8'h20, 32'hFFFF);
    rd(8'h20, d);
    chk(d, 32'h0);
    $display("test registers done");
  endtask

  // short on one output of each pair, held after clearing
  task automatic t_latch();
    int k;
    wr(sol_pkg::REG_LATCH, 32'h2);
    wr(sol_pkg::REG_IRQ_MASK, 32'h1F);
    wr(sol_pkg::REG_OUTREQ, 32'hF);
    w(6);
    chk({28'h0, out_drv}, 32'hF);
    chk({28'h0, out_status}, 32'hF);
    stuck_lo <= 4'h9;
    w(6);
    chk({28'h0, out_drv}, 32'h0);
    // only the faulted outputs report FALSE, their partners are just off
    chk({28'h0, out_status}, 32'h6);
    chk({31'h0, irq}, 32'h1);
    stuck_lo <= 4'h0;
    w(900);
    chk({28'h0, out_status & 4'h9}, 32'h0);
    chk({28'h0, out_drv}, 32'h0);
    k = 0;
    while (out_status !== 4'hF && k < 3500) begin
      w(1);
      k++;
    end
    chk({28'h0, out_status}, 32'hF);
    rd(sol_pkg::REG_IRQ_STAT, d);
    chk(d & 32'h9, 32'h9);
    wr(sol_pkg::REG_IRQ_STAT, 32'h1F);
    w(3);
    chk({31'h0, irq}, 32'h0);
    $display("test latch done");
  endtask

  // contact to 24v missed while on without pulses, caught once off
  task automatic t_detect();
    wr(sol_pkg::REG_LATCH, 32'h0);
    wr(sol_pkg::REG_CTRL, 32'h0);
    wr(sol_pkg::REG_OUTREQ, 32'h1);
    stuck_hi <= 4'h1;
    w(20);
    chk({31'h0, out_status[0]}, 32'h1);
    chk({31'h0, out_drv[0]}, 32'h1);
    wr(sol_pkg::REG_OUTREQ, 32'h0);
    w(10);
    chk({31'h0, out_status[0]}, 32'h0);
    stuck_hi <= 4'h0;
    w(10);
    chk({28'h0, out_status}, 32'hF);
    $display("test detect done");
  endtask

  task automatic t_dual();
    wr(sol_pkg::REG_CTRL, 32'h1);
    wr(sol_pkg::REG_OUTREQ, 32'h1);
    w(6);
    chk({28'h0, out_drv}, 32'h0);
    chk({28'h0, out_status}, 32'hC);
    wr(sol_pkg::REG_OUTREQ, 32'h3);
    w(6);
    chk({28'h0, out_drv}, 32'h3);
    chk({28'h0, out_status}, 32'hF);
    $display("test dual done");
  endtask

  task automatic t_pwr();
    for (int i = 0; i < 2; i++) begin
      wr(sol_pkg::REG_IRQ_STAT, 32'h1F);
      pwr_low <= (i == 0);
      pwr_high <= (i == 1);
      w(3);
      chk({28'h0, out_drv}, 32'h0);
      chk({28'h0, out_status}, 32'h0);
      chk({31'h0, pwr_ok}, 32'h0);
      rd(sol_pkg::REG_IRQ_STAT, d);
      chk(d & 32'h10, 32'h10);
      pwr_low <= 1'b0;
      pwr_high <= 1'b0;
      w(6);
      chk({31'h0, pwr_ok}, 32'h1);
      chk({28'h0, out_drv}, 32'h3);
    end
    $display("test supply done");
  endtask

  // pulse width on a clean output, contact and short caught on a pulsed dual pair
  task automatic t_pulse();
    int k;
    int n;
    wr(sol_pkg::REG_IRQ_STAT, 32'h1F);
    wr(sol_pkg::REG_LATCH, 32'h0);
    wr(sol_pkg::REG_TPW, {25'h0, sol_pkg::TP_W_MIN});
    wr(sol_pkg::REG_CTRL, 32'hA1);
    wr(sol_pkg::REG_OUTREQ, 32'hB);
    stuck_hi <= 4'h2;
    w(6);
    chk({28'h0, out_drv}, 32'hB);
    chk({28'h0, out_status}, 32'hF);
    // odd outputs pulse half a period into the cycle
    k = 0;
    while (out_drv[3] !== 1'b0 && k < 30000) begin
      w(1);
      k++;
    end
    n = 0;
    while (out_drv[3] === 1'b0 && n < 200) begin
      w(1);
      n++;
    end
    chk(n, sol_pkg::TP_W_MIN * TB_TICK);
    w(3);
    chk({28'h0, out_drv}, 32'h8);
    chk({28'h0, out_status}, 32'hD);
    rd(sol_pkg::REG_IRQ_STAT, d);
    chk(d, 32'h3);
    stuck_hi <= 4'h0;
    w(6);
    chk({28'h0, out_drv}, 32'hB);
    chk({28'h0, out_status}, 32'hF);
    $display("test pulse done");
  endtask

  ////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    w(5);
    rst_n <= 1'b1;
    w(2);
    t_reset();
    t_regs();
    t_latch();
    t_detect();
    t_dual();
    t_pwr();
    t_pulse();
    wrap_up();
  end
endmodule

`default_nettype wire
